// File: src/chr_pkg.sv
/*
 package of constants for the chronometer control logic: timing, uart framing,
 display codes and error codes. assumes a 25 MHz clock.
*/
// Behaviour
// - serial link 9600 baud, 8N1 both ways
// - left press steps flight timer start/stop/reset
// - left press in setting decrements selected value
// - middle toggles utc/local, long press enters setting
// - right press steps elapsed timer start/stop/reset
// - right press in setting increments selected value
// - clean power-up enters normal operating mode
// - weak battery shows low or defective warning
// - battery warning cleared after five seconds
// - internal error halts, dashes, error code shown
// - error codes three digits, 001 no battery
// - watchdog restarts logic when not serviced
// - clock counts 24 hours, utc or local
// - flight timer automatic or manual by configuration
// - elapsed timer split freezes shown reading
// - clock and both timers shown together
// - flight switch starts timer, level configurable
package chr_pkg;
	localparam int unsigned CLK_HZ        = 25000000;
	localparam int unsigned BAUD          = 9600;
	localparam int unsigned BIT_CYC       = CLK_HZ / BAUD;
	localparam int unsigned DATA_BITS     = 8;
	localparam int unsigned STOP_BITS     = 1;
	localparam int unsigned WARN_S        = 5;
	localparam int unsigned DEB_MS        = 20;
	localparam int unsigned DEB_CYC       = CLK_HZ / 1000 * DEB_MS;
	localparam int unsigned LONG_MS       = 2000;
	localparam int unsigned LONG_CYC      = CLK_HZ / 1000 * LONG_MS;
	localparam int unsigned WDOG_MS       = 1000;
	localparam int unsigned WDOG_CYC      = CLK_HZ / 1000 * WDOG_MS;
	localparam int unsigned DAY_S         = 86400;
	localparam logic [11:0] ERR_NO_BATT   = 12'h001;
	localparam logic [1:0]  BATT_OK       = 2'h0;
	localparam logic [1:0]  BATT_LOW      = 2'h1;
	localparam logic [1:0]  BATT_DEF      = 2'h2;
	localparam logic [1:0]  BATT_NONE     = 2'h3;
	localparam logic [1:0]  LINE3_MODE    = 2'h0;
	localparam logic [1:0]  LINE3_LOW     = 2'h1;
	localparam logic [1:0]  LINE3_DEF     = 2'h2;
	localparam logic [1:0]  LINE3_ERR     = 2'h3;
	typedef enum logic [1:0] {CHR_IDLE, CHR_RUN, CHR_STOP} chr_tmr_t;
	typedef enum logic [1:0] {CHR_START, CHR_WARN, CHR_NORM, CHR_HALT} chr_mode_t;
endpackage

// File: src/chr_core.sv
/*
 chronometer control logic: buttons, clock, timers, start-up warning, error halt,
 watchdog and 8N1 uart. assumes raw button, switch and rx pins asynchronous;
 display driver consumes binary seconds and line codes.
*/
`timescale 1ns/10ps
`default_nettype none
module chr_core
	import chr_pkg::*;
#(
	parameter int unsigned SEC_CYC  = CLK_HZ,
	parameter int unsigned DEB_N    = DEB_CYC,
	parameter int unsigned LONG_N   = LONG_CYC,
	parameter int unsigned WDOG_N   = WDOG_CYC
)(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        btn_left,
	input  wire logic        btn_mid,
	input  wire logic        btn_right,
	input  wire logic        flight_sw,
	input  wire logic        cfg_sw_active,
	input  wire logic        cfg_ft_auto,
	input  wire logic        btn_split,
	input  wire logic [1:0]  batt_level,
	input  wire logic        wdog_kick,
	input  wire logic        rx_data,
	output logic             tx_data,
	output logic [16:0]      clock_utc,
	output logic [16:0]      clock_shown,
	output logic             show_local,
	output logic             set_mode,
	output logic [16:0]      flight_timer,
	output logic [16:0]      elapsed_shown,
	output logic [1:0]       line3_code,
	output logic [11:0]      err_code,
	output logic             halted,
	output logic             wdog_reset,
	output logic [7:0]       rx_byte,
	output logic             rx_valid
);
	function automatic logic [16:0] wrap_inc(input logic [16:0] v);
		return (v == 17'(DAY_S - 1)) ? 17'h0 : v + 17'h1;
	endfunction
	function automatic logic [16:0] wrap_dec(input logic [16:0] v);
		return (v == 17'h0) ? 17'(DAY_S - 1) : v - 17'h1;
	endfunction

	// two-flop synchronisers; first stage read only by second
	logic [5:0] s1_q, s2_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= 6'h21; // buttons and switch idle low, rx idle high: no false edge
			s2_q <= 6'h21;
		end else begin
			s1_q <= {rx_data, flight_sw, btn_right, btn_mid, btn_left, 1'b1};
			s2_q <= s1_q;
		end
	end

	// debounce: level must hold DEB_N cycles before it counts; one press one pulse
	logic [2:0]  deb_q;
	logic [2:0]  prs_q;
	logic [31:0] dcnt_q [3];
	always_ff @(posedge clk) begin
		for (int i = 0; i < 3; i++) begin
			if (rst) begin
				deb_q[i]  <= 1'b0;
				prs_q[i]  <= 1'b0;
				dcnt_q[i] <= 32'h0;
			end else if (s2_q[i+1] == deb_q[i]) begin
				dcnt_q[i] <= 32'h0;
				prs_q[i]  <= 1'b0;
			end else if (dcnt_q[i] == 32'(DEB_N - 1)) begin
				deb_q[i]  <= s2_q[i+1];
				prs_q[i]  <= s2_q[i+1];
				dcnt_q[i] <= 32'h0;
			end else begin
				dcnt_q[i] <= dcnt_q[i] + 32'h1;
				prs_q[i]  <= 1'b0;
			end
		end
	end

	// middle held long enters/leaves setting, short toggles utc/local on release outside setting
	logic [31:0] hold_q;
	logic        mid_rel;
	logic        long_done_q;
	logic        deb_mid_d1_q;
	assign mid_rel = deb_mid_d1_q && !deb_q[1];
	always_ff @(posedge clk) begin
		if (rst) begin
			hold_q       <= 32'h0;
			long_done_q  <= 1'b0;
			deb_mid_d1_q <= 1'b0;
		end else begin
			deb_mid_d1_q <= deb_q[1];
			hold_q       <= deb_q[1] ? hold_q + 32'h1 : 32'h0;
			if (!deb_q[1])
				long_done_q <= 1'b0;
			else if (hold_q == 32'(LONG_N - 1))
				long_done_q <= 1'b1;
		end
	end

	// operating mode: start, warning, normal, halt
	chr_mode_t   mode_q;
	logic [31:0] sec_q;
	logic        tick;
	logic [2:0]  warn_s_q;
	logic        run;
	assign tick = (sec_q == 32'(SEC_CYC - 1));
	assign run  = (mode_q == CHR_NORM) || (mode_q == CHR_WARN);
	always_ff @(posedge clk) begin
		if (rst || wdog_reset)
			sec_q <= 32'h0;
		else
			sec_q <= tick ? 32'h0 : sec_q + 32'h1;
	end

	always_ff @(posedge clk) begin
		if (rst || wdog_reset) begin
			mode_q     <= CHR_START;
			warn_s_q   <= 3'h0;
			line3_code <= LINE3_MODE;
			err_code   <= 12'h0;
			halted     <= 1'b0;
		end else begin
			case (mode_q)
			CHR_START: begin
				if (batt_level == BATT_NONE) begin
					mode_q     <= CHR_HALT;
					err_code   <= ERR_NO_BATT;
					line3_code <= LINE3_ERR;
					halted     <= 1'b1;
				end else if (batt_level == BATT_OK) begin
					mode_q <= CHR_NORM;
				end else begin
					mode_q     <= CHR_WARN;
					line3_code <= (batt_level == BATT_DEF) ? LINE3_DEF : LINE3_LOW;
				end
			end
			CHR_WARN: begin
				if (tick)
					warn_s_q <= warn_s_q + 3'h1;
				if (tick && warn_s_q == 3'(WARN_S - 1)) begin
					mode_q     <= CHR_NORM;
					line3_code <= LINE3_MODE;
				end
			end
			CHR_NORM: ;
			CHR_HALT: ;
			default: mode_q <= CHR_START;
			endcase
		end
	end

	// watchdog: missing service for WDOG_N cycles pulses a restart
	logic [31:0] wd_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			wd_q       <= 32'h0;
			wdog_reset <= 1'b0;
		end else if (wdog_kick || wdog_reset) begin
			wd_q       <= 32'h0;
			wdog_reset <= 1'b0;
		end else if (wd_q == 32'(WDOG_N - 1)) begin
			wd_q       <= 32'h0;
			wdog_reset <= 1'b1;
		end else begin
			wd_q <= wd_q + 32'h1;
		end
	end

	// clock, local offset and setting; setting edits whichever zone is shown
	logic [16:0] loc_off_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			clock_utc  <= 17'h0;
			loc_off_q  <= 17'h0;
			show_local <= 1'b0;
			set_mode   <= 1'b0;
		end else if (run) begin
			if (hold_q == 32'(LONG_N - 1) && !long_done_q)
				set_mode <= !set_mode;
			else if (mid_rel && !long_done_q && !set_mode)
				show_local <= !show_local;
			if (set_mode && show_local && prs_q[0])
				loc_off_q <= wrap_dec(loc_off_q);
			else if (set_mode && show_local && prs_q[2])
				loc_off_q <= wrap_inc(loc_off_q);
			if (set_mode && !show_local && prs_q[0])
				clock_utc <= wrap_dec(clock_utc);
			else if (set_mode && !show_local && prs_q[2])
				clock_utc <= wrap_inc(clock_utc);
			else if (tick)
				clock_utc <= wrap_inc(clock_utc);
		end
	end

	// displayed clock registered, updating with elapsed_shown one cycle after clock_utc and flight_timer
	logic [17:0] loc_sum;
	assign loc_sum = {1'b0, clock_utc} + {1'b0, loc_off_q}; // two days need 18 bits
	always_ff @(posedge clk) begin
		if (rst)
			clock_shown <= 17'h0;
		else if (!show_local)
			clock_shown <= clock_utc;
		else if (loc_sum >= 18'(DAY_S))
			clock_shown <= 17'(loc_sum - 18'(DAY_S));
		else
			clock_shown <= loc_sum[16:0];
	end

	// flight timer: manual by button, automatic by configured switch level
	chr_tmr_t ft_q;
	logic     sw_on;
	assign sw_on = (s2_q[4] == cfg_sw_active);
	always_ff @(posedge clk) begin
		if (rst) begin
			ft_q         <= CHR_IDLE;
			flight_timer <= 17'h0;
		end else if (run) begin
			if (cfg_ft_auto) begin
				ft_q <= sw_on ? CHR_RUN : (ft_q == CHR_RUN ? CHR_STOP : ft_q);
				if (!set_mode && prs_q[0] && !sw_on) begin
					ft_q         <= CHR_IDLE;
					flight_timer <= 17'h0;
				end
			end else if (!set_mode && prs_q[0]) begin
				case (ft_q)
				CHR_IDLE: ft_q <= CHR_RUN;
				CHR_RUN:  ft_q <= CHR_STOP;
				CHR_STOP: begin
					ft_q         <= CHR_IDLE;
					flight_timer <= 17'h0;
				end
				default:  ft_q <= CHR_IDLE;
				endcase
			end
			if (ft_q == CHR_RUN && tick)
				flight_timer <= wrap_inc(flight_timer);
		end
	end

	// elapsed timer with split: display freezes while counting continues
	chr_tmr_t    et_q;
	logic [16:0] et_cnt_q;
	logic        split_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			et_q          <= CHR_IDLE;
			et_cnt_q      <= 17'h0;
			split_q       <= 1'b0;
			elapsed_shown <= 17'h0;
		end else if (run) begin
			if (!set_mode && prs_q[2]) begin
				case (et_q)
				CHR_IDLE: et_q <= CHR_RUN;
				CHR_RUN:  et_q <= CHR_STOP;
				CHR_STOP: begin
					et_q     <= CHR_IDLE;
					et_cnt_q <= 17'h0;
				end
				default:  et_q <= CHR_IDLE;
				endcase
			end
			if (btn_split && et_q == CHR_RUN)
				split_q <= !split_q;
			if (et_q == CHR_RUN && tick)
				et_cnt_q <= wrap_inc(et_cnt_q);
			if (!split_q)
				elapsed_shown <= et_cnt_q;
		end
	end

	// uart receiver 8N1, mid-bit sampling
	logic [15:0] rx_cnt_q;
	logic [3:0]  rx_bit_q;
	logic [7:0]  rx_sh_q;
	logic        rx_busy_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_cnt_q  <= 16'h0;
			rx_bit_q  <= 4'h0;
			rx_sh_q   <= 8'h0;
			rx_busy_q <= 1'b0;
			rx_byte   <= 8'h0;
			rx_valid  <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (!rx_busy_q) begin
				if (!s2_q[5]) begin
					rx_busy_q <= 1'b1;
					rx_cnt_q  <= 16'(BIT_CYC / 2);
					rx_bit_q  <= 4'h0;
				end
			end else if (rx_cnt_q != 16'h0) begin
				rx_cnt_q <= rx_cnt_q - 16'h1;
			end else begin
				rx_cnt_q <= 16'(BIT_CYC - 1);
				rx_bit_q <= rx_bit_q + 4'h1;
				if (rx_bit_q == 4'h0 && s2_q[5])
					rx_busy_q <= 1'b0; // false start
				else if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'(DATA_BITS))
					rx_sh_q <= {s2_q[5], rx_sh_q[7:1]};
				else if (rx_bit_q == 4'(DATA_BITS + STOP_BITS)) begin
					rx_busy_q <= 1'b0;
					rx_byte   <= rx_sh_q;
					rx_valid  <= s2_q[5]; // framing error drops byte
				end
			end
		end
	end

	// uart transmitter 8N1: echoes each good byte, idles high
	logic [15:0] tx_cnt_q;
	logic [9:0]  tx_sh_q;
	logic [3:0]  tx_left_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_cnt_q  <= 16'h0;
			tx_sh_q   <= 10'h3ff;
			tx_left_q <= 4'h0;
			tx_data   <= 1'b1;
		end else if (tx_left_q == 4'h0) begin
			tx_data <= 1'b1;
			if (rx_valid) begin
				tx_sh_q   <= {1'b1, rx_byte, 1'b0};
				tx_left_q <= 4'(DATA_BITS + STOP_BITS + 1);
				tx_cnt_q  <= 16'h0;
			end
		end else if (tx_cnt_q == 16'h0) begin
			tx_data   <= tx_sh_q[0];
			tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
			tx_left_q <= tx_left_q - 4'h1;
			tx_cnt_q  <= 16'(BIT_CYC - 1);
		end else begin
			tx_cnt_q <= tx_cnt_q - 16'h1;
		end
	end

	a_halt_latch: assert property (@(posedge clk) disable iff (rst || wdog_reset)
		(mode_q == CHR_HALT) |=> halted && line3_code == LINE3_ERR)
		else $error("halt lost error display");
	a_err_code: assert property (@(posedge clk) disable iff (rst)
		halted |-> err_code == 12'h001)
		else $error("wrong error code");
	a_start_norm: assert property (@(posedge clk) disable iff (rst || wdog_reset)
		(mode_q == CHR_START && batt_level == BATT_OK) |=> mode_q == CHR_NORM)
		else $error("clean start not normal");
	a_warn_line: assert property (@(posedge clk) disable iff (rst || wdog_reset)
		(mode_q == CHR_START && batt_level == BATT_DEF) |=> line3_code == LINE3_DEF)
		else $error("defective warning missing");
	a_warn_hold: assert property (@(posedge clk) disable iff (rst || wdog_reset)
		(mode_q == CHR_WARN) |-> line3_code != LINE3_MODE)
		else $error("warning dropped early");
	a_clock_wrap: assert property (@(posedge clk) disable iff (rst)
		clock_utc < 17'(DAY_S))
		else $error("clock past 24 h");
	a_ft_manual: assert property (@(posedge clk) disable iff (rst || wdog_reset)
		(run && !cfg_ft_auto && !set_mode && prs_q[0] && ft_q == CHR_IDLE)
		|=> ft_q == CHR_RUN)
		else $error("flight timer not started");
	a_et_step: assert property (@(posedge clk) disable iff (rst || wdog_reset)
		(run && !set_mode && prs_q[2] && et_q == CHR_RUN) |=> et_q == CHR_STOP)
		else $error("elapsed timer not stopped");
	a_press_once: assert property (@(posedge clk) disable iff (rst)
		prs_q[0] |=> !prs_q[0])
		else $error("press gave two actions");
	a_tx_idle: assert property (@(posedge clk) disable iff (rst)
		(tx_left_q == 4'h0 && !rx_valid) |=> tx_data)
		else $error("tx not idle high");
	c_warn_end: cover property (@(posedge clk) mode_q == CHR_WARN ##1 mode_q == CHR_NORM);
	c_set_mode: cover property (@(posedge clk) !set_mode ##1 set_mode);
	c_rx_byte: cover property (@(posedge clk) rx_valid);
	c_wdog: cover property (@(posedge clk) wdog_reset);
endmodule
`default_nettype wire

// File: tb/chr_pilot_box.sv
/*
 partner model: the pilot's three push buttons and the serial test box.
 assumes the core samples its raw pins on the rising edge of clk.
*/
`timescale 1ns/10ps
`default_nettype none
module chr_pilot_box
	import chr_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  tx_data,
	output logic       btn_left,
	output logic       btn_mid,
	output logic       btn_right,
	output logic       rx_data,
	output logic [7:0] tx_seen,
	output logic       tx_ok
);
	// released buttons read low, an idle serial line rests at mark
	initial begin
		btn_left = 1'b0;
		btn_mid = 1'b0;
		btn_right = 1'b0;
		rx_data = 1'b1;
		tx_seen = 8'h00;
		tx_ok = 1'b0;
	end

	task automatic set_btn(input int which, input logic v);
		case (which)
			0: btn_left <= v;
			1: btn_mid <= v;
			default: btn_right <= v;
		endcase
	endtask

	// contact bounces once before settling, so one press must still act once
	task automatic press(input int which, input int hold);
		int i;
		for (i = 0; i < hold + 2; i++) begin
			@(posedge clk);
			set_btn(which, i != 1);
		end
		@(posedge clk);
		set_btn(which, 1'b0);
		repeat (16) @(posedge clk);
	endtask

	// one frame: start low, eight data bits lsb first, one stop high
	task automatic send_byte(input logic [7:0] b);
		int i;
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (i = 0; i < 10; i++) begin
			@(posedge clk);
			rx_data <= fr[i];
			repeat (BIT_CYC - 1) @(posedge clk);
		end
	endtask

	// catch the echo, sampling each bit in its middle
	task automatic get_byte();
		int i;
		tx_ok = 1'b0;
		for (i = 0; i < 12 * BIT_CYC && tx_data !== 1'b0; i++) @(posedge clk);
		repeat (BIT_CYC / 2) @(posedge clk);
		for (i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge clk);
			tx_seen[i] = tx_data;
		end
		repeat (BIT_CYC) @(posedge clk);
		tx_ok = (tx_data === 1'b1);
	endtask
endmodule
`default_nettype wire

// File: tb/chr_core_tb_top.sv
/*
 self-checking bench for the chronometer core with shortened counts.
 assumes the pilot box model drives buttons and the serial line.
*/
`timescale 1ns/10ps
`default_nettype none
module chr_core_tb_top
	import chr_pkg::*;
;
	localparam int WDG = 200;
	logic clk, rst, flight_sw, cfg_sw_active, cfg_ft_auto, btn_split, wdog_kick;
	logic btn_left, btn_mid, btn_right, rx_data, tx_data, show_local, set_mode;
	logic halted, wdog_reset, rx_valid, tx_ok, kick_en;
	logic [1:0]  batt_level, line3_code;
	logic [7:0]  rx_byte, tx_seen;
	logic [11:0] err_code;
	logic [16:0] clock_utc, clock_shown, flight_timer, elapsed_shown;
	int err_total, checked, kick_cnt;

	chr_core #(.SEC_CYC(10), .DEB_N(4), .LONG_N(20), .WDOG_N(WDG)) dut (.clk(clk),
		.rst(rst), .btn_left(btn_left), .btn_mid(btn_mid), .btn_right(btn_right),
		.flight_sw(flight_sw), .cfg_sw_active(cfg_sw_active), .cfg_ft_auto(cfg_ft_auto),
		.btn_split(btn_split), .batt_level(batt_level), .wdog_kick(wdog_kick),
		.rx_data(rx_data), .tx_data(tx_data), .clock_utc(clock_utc),
		.clock_shown(clock_shown), .show_local(show_local), .set_mode(set_mode),
		.flight_timer(flight_timer), .elapsed_shown(elapsed_shown),
		.line3_code(line3_code), .err_code(err_code), .halted(halted),
		.wdog_reset(wdog_reset), .rx_byte(rx_byte), .rx_valid(rx_valid));
	chr_pilot_box box (.clk(clk), .tx_data(tx_data), .btn_left(btn_left),
		.btn_mid(btn_mid), .btn_right(btn_right), .rx_data(rx_data),
		.tx_seen(tx_seen), .tx_ok(tx_ok));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// software stand-in servicing the watchdog well inside its interval
	always @(posedge clk) begin
		kick_cnt <= kick_cnt + 1;
		wdog_kick <= kick_en && (kick_cnt % 64 == 0);
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic do_reset(input logic [1:0] lvl);
		@(posedge clk);
		rst <= 1'b1;
		batt_level <= lvl;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	function automatic logic [16:0] tmr(input int which);
		return (which == 0) ? flight_timer : elapsed_shown;
	endfunction

	// offset of the shown zone, read while the utc seconds stand still
	task automatic get_offs(output int o);
		int i;
		logic [16:0] a;
		for (i = 0; i < 4; i++) begin
			a = clock_utc;
			repeat (2) @(posedge clk);
			if (clock_utc === a) break;
		end
		o = (int'(clock_shown) + DAY_S - int'(clock_utc)) % DAY_S;
	endtask

	task automatic split_pulse();
		@(posedge clk);
		btn_split <= 1'b1;
		@(posedge clk);
		btn_split <= 1'b0;
		repeat (2) @(posedge clk); // let the frozen reading settle before it is read
	endtask

	task automatic t_batt();
		logic [1:0] lvl;
		for (lvl = BATT_LOW; lvl <= BATT_DEF; lvl++) begin
			do_reset(lvl);
			repeat (10) @(posedge clk);
			check("warn line", line3_code, (lvl == BATT_LOW) ? LINE3_LOW : LINE3_DEF);
			repeat (70) @(posedge clk);
			check("warn gone", line3_code, LINE3_MODE);
		end
		do_reset(BATT_OK);
		check("normal", {halted, set_mode, line3_code}, {2'b00, LINE3_MODE});
		$display("test battery done");
	endtask

	// start, stop, clear; the elapsed timer also gets a split
	task automatic t_timer(input int which);
		logic [16:0] a;
		box.press(which, 8);
		a = tmr(which);
		repeat (30) @(posedge clk);
		check("timer runs", tmr(which) > a, 1'b1);
		if (which == 2) begin
			split_pulse();
			a = tmr(which);
			repeat (30) @(posedge clk);
			check("split holds", tmr(which), a);
			split_pulse();
			repeat (30) @(posedge clk);
			check("split ends", tmr(which) > a, 1'b1);
		end
		box.press(which, 8);
		a = tmr(which);
		repeat (30) @(posedge clk);
		check("timer stops", tmr(which), a);
		check("clock runs", clock_utc > 17'h00000, 1'b1);
		box.press(which, 8);
		check("timer clears", tmr(which), 17'h00000);
		$display("test timer %0d done", which);
	endtask

	// automatic flight mode: the configured switch level runs and stops the timer
	task automatic t_auto();
		logic [16:0] a;
		@(posedge clk);
		cfg_ft_auto <= 1'b1;
		cfg_sw_active <= 1'b1;
		flight_sw <= 1'b1;
		a = flight_timer;
		repeat (40) @(posedge clk);
		check("auto runs", flight_timer > a, 1'b1);
		flight_sw <= 1'b0;
		repeat (5) @(posedge clk);
		a = flight_timer;
		repeat (30) @(posedge clk);
		check("auto stops", flight_timer, a);
		box.press(0, 8);
		check("auto clears", flight_timer, 17'h00000);
		cfg_ft_auto <= 1'b0;
		cfg_sw_active <= 1'b0;
		$display("test auto flight done");
	endtask

	task automatic t_zone();
		int o0, o1;
		box.press(1, 8);
		check("local shown", show_local, 1'b1);
		box.press(1, 30);
		check("setting", set_mode, 1'b1);
		get_offs(o0);
		box.press(0, 8);
		get_offs(o1);
		check("decrement", o1, (o0 + DAY_S - 1) % DAY_S);
		box.press(2, 8);
		get_offs(o1);
		check("increment", o1, o0);
		box.press(1, 30);
		check("setting left", set_mode, 1'b0);
		box.press(1, 8);
		check("utc shown", show_local, 1'b0);
		$display("test zone done");
	endtask

	task automatic t_halt();
		do_reset(BATT_NONE);
		repeat (10) @(posedge clk);
		check("halted", {halted, line3_code}, {1'b1, LINE3_ERR});
		check("err code", err_code, ERR_NO_BATT);
		box.press(0, 8);
		repeat (30) @(posedge clk);
		check("halt frozen", flight_timer, 17'h00000);
		do_reset(BATT_OK);
		$display("test halt done");
	endtask

	task automatic t_wdog();
		int n;
		for (n = 0; n < 80 && wdog_kick !== 1'b1; n++) @(negedge clk);
		@(posedge clk);
		kick_en <= 1'b0;
		for (n = 0; n < 2 * WDG && wdog_reset !== 1'b1; n++) @(negedge clk);
		check("wdog delay", n >= WDG - 5 && n <= WDG + 5, 1'b1);
		@(posedge clk);
		kick_en <= 1'b1;
		repeat (10) @(posedge clk);
		check("restarted", {halted, line3_code}, {1'b0, LINE3_MODE});
		$display("test watchdog done");
	endtask

	task automatic t_uart();
		int i;
		fork
			box.send_byte(8'ha5);
			box.get_byte();
			begin
				for (i = 0; i < 12 * BIT_CYC && rx_valid !== 1'b1; i++) @(negedge clk);
				check("rx valid", rx_valid, 1'b1);
				check("rx byte", rx_byte, 8'ha5);
			end
		join
		check("echo", {tx_ok, tx_seen}, {1'b1, 8'ha5});
		$display("test serial done");
	endtask

	initial begin
		{rst, flight_sw, cfg_sw_active, cfg_ft_auto, btn_split} = 5'b10000;
		{batt_level, err_total, checked} = 0;
		kick_en = 1'b1;
		do_reset(BATT_OK);
		t_batt();
		t_timer(0);
		t_auto();
		t_timer(2);
		t_zone();
		t_halt();
		t_wdog();
		t_uart();
		tally_and_finish();
	end
endmodule
`default_nettype wire
